// ### logic/sia_map.vh
// constants for the slave I/O image allocator: word counts, bases, kinds
// assumes a single 200 MHz clock and a synchronous active-low reset
// How it works
// - narrow range uses ten words: 4/4/2.
// - wide range uses twenty words: 8/8/4.
// - first family base is 2000 + 10n.
// - second family base splits at unit ten.
// - input and output node numbers are independent.
// - narrow range accepts nodes 0 to 7.
// - wide range accepts nodes 0 to 15.
// - sixteen points take an aligned node pair.
// - 8-in/8-out slave uses one node both ways.
// - four points use low nibble of slot.
// - 4-in/4-out slave uses same nibble both ways.
// - thirty-two points take four slots, pair aligned.
// - 16-in/16-out slave takes pair both ways.
// - analog spans 8/6 slots, pair aligned.
// - span past allocation refused, link indicator off.
// - active flag set once node participates.
// - restart and power-up clear all flags.
// - active flag stays set after dropout.
// - error flag set on dropout of an active node, cleared by rejoin.
`ifndef SIA_MAP_VH
`define SIA_MAP_VH

`define SIA_BASE_F0      16'h07D0
`define SIA_BASE_F1_LO   16'h0064
`define SIA_BASE_F1_HI   16'h0190
`define SIA_UNIT_STRIDE  16'h000A
`define SIA_UNIT_SPLIT   4'hA

`define SIA_WORDS_NARROW 5'h0A
`define SIA_WORDS_WIDE   5'h14
`define SIA_DATA_NARROW  16'h0004
`define SIA_DATA_WIDE    16'h0008
`define SIA_NODES_NARROW 5'h08
`define SIA_NODES_WIDE   5'h10

`define SIA_KIND_P4      3'h0
`define SIA_KIND_P8      3'h1
`define SIA_KIND_P16     3'h2
`define SIA_KIND_P32     3'h3
`define SIA_KIND_A48     3'h4
`define SIA_KIND_A64     3'h5

`define SIA_SLOTS_1      4'h1
`define SIA_SLOTS_2      4'h2
`define SIA_SLOTS_4      4'h4
`define SIA_SLOTS_6      4'h6
`define SIA_SLOTS_8      4'h8
`define SIA_SLOTS_NONE   4'h0

`define SIA_MASK_NIB_LO  16'h000F
`define SIA_MASK_NIB_HI  16'h0F00
`define SIA_MASK_BYTE_LO 16'h00FF
`define SIA_MASK_BYTE_HI 16'hFF00
`define SIA_MASK_WORD    16'hFFFF

`define SIA_SYNC_BITS    6

`endif

// ### logic/sia_base_calc.v
// first image word from the unit number and the host family
// assumes settings already synchronised to the clock
`timescale 1ns/1ps
`include "sia_map.vh"
module sia_base_calc (
  // settings
  input  wire        family_sel,
  input  wire [3:0]  unit_num,
  // result
  output reg  [15:0] base_word
);

  wire [15:0] unit_w = {12'h000, unit_num};

  always @* begin
    if (!family_sel) begin
      base_word = `SIA_BASE_F0 + unit_w * `SIA_UNIT_STRIDE;
    end else if (unit_num < `SIA_UNIT_SPLIT) begin
      base_word = `SIA_BASE_F1_LO + unit_w * `SIA_UNIT_STRIDE;
    end else begin
      base_word = `SIA_BASE_F1_HI + (unit_w - {12'h000, `SIA_UNIT_SPLIT}) * `SIA_UNIT_STRIDE;
    end
  end

endmodule

// ### logic/sia_span_calc.v
// node span of one slave: first slot, slot count, fit, first-word bit mask
// assumes node and kind stable while the caller samples the result
`timescale 1ns/1ps
`include "sia_map.vh"
module sia_span_calc (
  // request
  input  wire [3:0]  node,
  input  wire [2:0]  kind,
  input  wire        wide,
  // result
  output reg  [3:0]  start_slot,
  output reg  [3:0]  slots,
  output reg  [15:0] first_mask,
  output wire        fits
);

  wire [4:0] limit = wide ? `SIA_NODES_WIDE : `SIA_NODES_NARROW;
  wire [4:0] span_end = {1'b0, start_slot} + {1'b0, slots};

  always @* begin
    case (kind)
      `SIA_KIND_P4:  slots = `SIA_SLOTS_1;
      `SIA_KIND_P8:  slots = `SIA_SLOTS_1;
      `SIA_KIND_P16: slots = `SIA_SLOTS_2;
      `SIA_KIND_P32: slots = `SIA_SLOTS_4;
      `SIA_KIND_A48: slots = `SIA_SLOTS_6;
      `SIA_KIND_A64: slots = `SIA_SLOTS_8;
      default:       slots = `SIA_SLOTS_NONE;
    endcase
    // multi-slot spans start on the even node of the pair
    if (slots == `SIA_SLOTS_1) begin
      start_slot = node;
    end else begin
      start_slot = {node[3:1], 1'b0};
    end
    if (kind == `SIA_KIND_P4) begin
      first_mask = node[0] ? `SIA_MASK_NIB_HI : `SIA_MASK_NIB_LO;
    end else if (kind == `SIA_KIND_P8) begin
      first_mask = node[0] ? `SIA_MASK_BYTE_HI : `SIA_MASK_BYTE_LO;
    end else begin
      first_mask = `SIA_MASK_WORD;
    end
  end

  assign fits = (slots != `SIA_SLOTS_NONE) && (span_end <= limit);

endmodule

// ### logic/sia_image_alloc.v
// slave I/O image allocator: maps slaves onto image words, keeps node flags
// assumes join/drop/restart come from same-clock logic; switches are asynchronous
`timescale 1ns/1ps
`include "sia_map.vh"
module sia_image_alloc (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // switch settings
  input  wire        node_range_wide,
  input  wire        host_family_sel,
  input  wire [3:0]  unit_num,
  // slave join request
  input  wire        join_valid,
  input  wire [3:0]  join_node,
  input  wire [2:0]  join_kind,
  input  wire        join_has_out,
  input  wire        join_has_in,
  // slave dropout event
  input  wire        drop_valid,
  input  wire [3:0]  drop_node,
  input  wire        drop_is_in,
  // restart
  input  wire        restart,
  // image layout
  output reg  [15:0] base_word_r,
  output reg  [4:0]  word_count_r,
  output reg  [15:0] in_area_word_r,
  output reg  [15:0] stat_area_word_r,
  // join result
  output reg         map_valid_r,
  output reg         map_refused_r,
  output reg  [15:0] map_out_word_r,
  output reg  [15:0] map_in_word_r,
  output reg  [15:0] map_mask_r,
  output reg  [3:0]  map_slots_r,
  // node status
  output reg  [15:0] active_out_r,
  output reg  [15:0] active_in_r,
  output reg  [15:0] err_out_r,
  output reg  [15:0] err_in_r,
  output reg         link_ok_indicator
);

  // switch synchronisers
  wire [`SIA_SYNC_BITS-1:0] sw_raw = {node_range_wide, host_family_sel, unit_num};
  wire [`SIA_SYNC_BITS-1:0] sw_s;
  genvar g;
  generate
    for (g = 0; g < `SIA_SYNC_BITS; g = g + 1) begin : g_sync
      reg s1_r;
      reg s2_r;
      always @(posedge ref_clk) begin
        if (!rstn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= sw_raw[g];
          s2_r <= s1_r;
        end
      end
      assign sw_s[g] = s2_r;
    end
  endgenerate

  wire       wide_s   = sw_s[5];
  wire       family_s = sw_s[4];
  wire [3:0] unit_s   = sw_s[3:0];

  wire [15:0] base_word;
  wire [3:0]  start_slot;
  wire [3:0]  slots;
  wire [15:0] first_mask;
  wire        fits;

  sia_base_calc u_base (
    .family_sel (family_s),
    .unit_num   (unit_s),
    .base_word  (base_word)
  );

  sia_span_calc u_span (
    .node       (join_node),
    .kind       (join_kind),
    .wide       (wide_s),
    .start_slot (start_slot),
    .slots      (slots),
    .first_mask (first_mask),
    .fits       (fits)
  );

  // area sizes for the current range setting
  wire [15:0] data_words = wide_s ? `SIA_DATA_WIDE : `SIA_DATA_NARROW;
  wire [4:0]  words_nxt  = wide_s ? `SIA_WORDS_WIDE : `SIA_WORDS_NARROW;
  wire [15:0] slot_word  = {13'h0000, start_slot[3:1]};
  wire [15:0] in_base    = base_word + data_words;
  wire [15:0] stat_base  = in_base + data_words;

  wire any_dir  = join_has_out | join_has_in;
  wire accept   = join_valid & fits & any_dir;
  wire refuse   = join_valid & ~accept;

  // per-direction one-hot node decodes; directions never share flags
  wire [15:0] join_dec = 16'h0001 << join_node;
  wire [15:0] drop_dec = 16'h0001 << drop_node;
  wire [15:0] set_ao   = (accept & join_has_out) ? join_dec : 16'h0000;
  wire [15:0] set_ai   = (accept & join_has_in)  ? join_dec : 16'h0000;
  wire [15:0] drop_o   = (drop_valid & ~drop_is_in) ? drop_dec : 16'h0000;
  wire [15:0] drop_i   = (drop_valid &  drop_is_in) ? drop_dec : 16'h0000;

  // image layout follows the synchronised switches
  always @(posedge ref_clk) begin
    if (!rstn) begin
      base_word_r      <= 16'h0000;
      word_count_r     <= 5'h00;
      in_area_word_r   <= 16'h0000;
      stat_area_word_r <= 16'h0000;
    end else begin
      base_word_r      <= base_word;
      word_count_r     <= words_nxt;
      in_area_word_r   <= in_base;
      stat_area_word_r <= stat_base;
    end
  end

  // join result, one pulse per request
  always @(posedge ref_clk) begin
    if (!rstn) begin
      map_valid_r    <= 1'b0;
      map_refused_r  <= 1'b0;
      map_out_word_r <= 16'h0000;
      map_in_word_r  <= 16'h0000;
      map_mask_r     <= 16'h0000;
      map_slots_r    <= 4'h0;
    end else begin
      map_valid_r   <= accept;
      map_refused_r <= refuse;
      if (accept) begin
        // same word positions in both areas for mixed slaves
        map_out_word_r <= base_word + slot_word;
        map_in_word_r  <= in_base + slot_word;
        map_mask_r     <= first_mask;
        map_slots_r    <= slots;
      end
    end
  end

  // node flags: active is sticky, error follows dropout, set beats clear
  always @(posedge ref_clk) begin
    if (!rstn || restart) begin
      active_out_r <= 16'h0000;
      active_in_r  <= 16'h0000;
      err_out_r    <= 16'h0000;
      err_in_r     <= 16'h0000;
    end else begin
      active_out_r <= active_out_r | set_ao;
      active_in_r  <= active_in_r | set_ai;
      err_out_r    <= (err_out_r & ~set_ao) | (drop_o & (active_out_r | set_ao));
      err_in_r     <= (err_in_r & ~set_ai) | (drop_i & (active_in_r | set_ai));
    end
  end

  // link indicator: lit by an accepted slave, dark after a refusal
  always @(posedge ref_clk) begin
    if (!rstn || restart) begin
      link_ok_indicator <= 1'b0;
    end else if (refuse) begin
      link_ok_indicator <= 1'b0;
    end else if (accept) begin
      link_ok_indicator <= 1'b1;
    end
  end

endmodule

// ### testbench/sia_host_model.sv
// host view of the image: first and last word the allocator takes
// assumes the same switch values that feed the allocator
`timescale 1ns/1ps
module sia_host_model (
  // switch settings
  input  logic        wide,
  input  logic        family_b,
  input  logic [3:0]  unit,
  // expected image
  output logic [15:0] first_word,
  output logic [15:0] last_word
);
  wire [15:0] u = {12'h000, unit};
  always_comb begin
    if (!family_b)
      first_word = 16'h07D0 + u * 16'h000A;
    else if (unit < 4'hA)
      first_word = 16'h0064 + u * 16'h000A;
    else
      first_word = 16'h0190 + (u - 16'h000A) * 16'h000A;
    last_word = first_word + (wide ? 16'h0013 : 16'h0009);
  end
endmodule

// ### testbench/sia_alloc_asserts.sv
// timing checks on the allocator's join answers and node flags
// assumes bound to sia_image_alloc, names matching its ports
`timescale 1ns/1ps
module sia_alloc_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // switches
  input wire logic        node_range_wide,
  input wire logic        host_family_sel,
  input wire logic [3:0]  unit_num,
  // join request and answer
  input wire logic        join_valid,
  input wire logic [3:0]  join_node,
  input wire logic [2:0]  join_kind,
  input wire logic        map_valid_r,
  input wire logic        map_refused_r,
  input wire logic [15:0] map_out_word_r,
  input wire logic [15:0] map_in_word_r,
  input wire logic [15:0] map_mask_r,
  input wire logic [3:0]  map_slots_r,
  // status
  input wire logic        restart,
  input wire logic        link_ok_indicator,
  input wire logic [15:0] active_out_r,
  input wire logic [15:0] err_out_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [2:0] settle_r;
  wire [15:0] gap = node_range_wide ? 16'h0008 : 16'h0004;
  wire        odd = join_node[0];
  // switches unchanged long enough for the sync stages
  always @(posedge ref_clk)
    settle_r <= (!rstn || !$stable({node_range_wide, host_family_sel, unit_num})) ? 3'h0
      : settle_r + {2'h0, settle_r != 3'h7};
  sequence nib_join; join_valid && join_kind == 3'h0 ##1 map_valid_r; endsequence
  sequence fit_join; settle_r == 3'h7 && join_valid ##1 map_valid_r; endsequence
  sequence high_narrow; settle_r == 3'h7 && join_valid && !node_range_wide && join_node[3]; endsequence
  sequence a64_join; join_valid && join_kind == 3'h5 ##1 map_valid_r; endsequence
  join_answer_a: assert property (join_valid |=> map_valid_r != map_refused_r)
    else $error("join answer missing");
  bad_kind_a: assert property (join_valid && join_kind > 3'h5 |=> map_refused_r && !link_ok_indicator)
    else $error("bad kind not refused");
  narrow_node_a: assert property (high_narrow |=> map_refused_r)
    else $error("high node taken in narrow range");
  nibble_mask_a: assert property (nib_join |-> map_mask_r == ($past(odd) ? 16'h0F00 : 16'h000F))
    else $error("nibble mask wrong");
  word_pair_a: assert property (fit_join |-> map_in_word_r == map_out_word_r + $past(gap))
    else $error("in word not paired to out word");
  slot_count_a: assert property (a64_join |-> map_slots_r == 4'h8)
    else $error("analog span slot count wrong");
  active_sticky_a: assert property (!restart |=> (active_out_r & $past(active_out_r)) == $past(active_out_r))
    else $error("active flag lost");
  restart_clear_a: assert property (restart |=> active_out_r == 16'h0000 && err_out_r == 16'h0000
    && !link_ok_indicator)
    else $error("restart left flags");
  err_active_a: assert property ((err_out_r & ~active_out_r) == 16'h0000)
    else $error("error flag on inactive node");
endmodule
bind sia_image_alloc sia_alloc_chk i_chk (.*);

// ### testbench/tb_top.sv
// self-checking bench for the slave I/O image allocator
// assumes the host model and checker compiled beside it
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic ref_clk = 0, rstn = 0, node_range_wide = 0, host_family_sel = 0, join_valid = 0;
  logic join_has_out = 0, join_has_in = 0, drop_valid = 0, drop_is_in = 0, restart = 0;
  logic [3:0] unit_num = 0, join_node = 0, drop_node = 0, map_slots_r;
  logic [2:0] join_kind = 0;
  logic [4:0] word_count_r;
  logic [15:0] base_word_r, in_area_word_r, stat_area_word_r, map_out_word_r, map_in_word_r;
  logic [15:0] map_mask_r, active_out_r, active_in_r, err_out_r, err_in_r, fw, lw;
  logic map_valid_r, map_refused_r, link_ok_indicator;
  int errors = 0, n_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  sia_image_alloc i_dut (.*);
  sia_host_model i_host (.wide(node_range_wide), .family_b(host_family_sel), .unit(unit_num),
    .first_word(fw), .last_word(lw));
  task automatic give_verdict;
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic setsw(input logic w, f, input logic [3:0] n);
    @(negedge ref_clk);
    node_range_wide = w; host_family_sel = f; unit_num = n;
    repeat (4) @(negedge ref_clk);
    `CHK(base_word_r, fw)
    `CHK(base_word_r + {11'h000, word_count_r} - 16'h0001, lw)
    `CHK({in_area_word_r, stat_area_word_r}, {fw + (w ? 16'h0008 : 16'h0004), fw + (w ? 16'h0010 : 16'h0008)})
  endtask
  task automatic attach(input logic [3:0] n, input logic [2:0] k, input logic o, i, ok,
                        input logic [15:0] off, m, input logic [3:0] s);
    logic [15:0] gap;
    logic [31:0] prior;
    gap = node_range_wide ? 16'h0008 : 16'h0004;
    @(negedge ref_clk);
    prior = {active_out_r, active_in_r};
    join_valid = 1; join_node = n; join_kind = k; join_has_out = o; join_has_in = i;
    @(negedge ref_clk);
    join_valid = 0;
    `CHK({map_valid_r, map_refused_r, link_ok_indicator}, {ok, !ok, ok})
    if (ok) begin
      `CHK({map_out_word_r, map_in_word_r, map_mask_r, map_slots_r}, {fw + off, fw + gap + off, m, s})
      `CHK({active_out_r[n] | !o, active_in_r[n] | !i}, 2'b11)
    end else begin
      `CHK({active_out_r, active_in_r}, prior)
    end
  endtask
  task automatic drop(input logic [3:0] n, input logic i);
    @(negedge ref_clk);
    drop_valid = 1; drop_node = n; drop_is_in = i;
    @(negedge ref_clk);
    drop_valid = 0;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("unexpected at %0t: run too long", $time);
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge ref_clk);
    rstn = 1;
    `CHK({active_out_r, active_in_r, err_out_r, err_in_r, link_ok_indicator}, 65'h0)
    for (int f = 0; f < 2; f++)
      for (int n = 0; n < 16; n += 5)
        setsw(n[0], f[0], n[3:0]);
    setsw(0, 0, 4'h3);
    attach(4'h5, 3'h2, 1, 0, 1, 16'h0002, 16'hFFFF, 4'h2);
    attach(4'h7, 3'h0, 0, 1, 1, 16'h0003, 16'h0F00, 4'h1);
    attach(4'h2, 3'h0, 1, 1, 1, 16'h0001, 16'h000F, 4'h1);
    attach(4'h2, 3'h1, 1, 1, 1, 16'h0001, 16'h00FF, 4'h1);
    attach(4'h1, 3'h3, 1, 0, 1, 16'h0000, 16'hFFFF, 4'h4);
    attach(4'h3, 3'h2, 1, 1, 1, 16'h0001, 16'hFFFF, 4'h2);
    attach(4'h5, 3'h3, 0, 1, 1, 16'h0002, 16'hFFFF, 4'h4);
    attach(4'h7, 3'h3, 1, 0, 0, 16'h0000, 16'h0000, 4'h0);
    attach(4'h8, 3'h1, 1, 0, 0, 16'h0000, 16'h0000, 4'h0);
    attach(4'h1, 3'h5, 0, 1, 1, 16'h0000, 16'hFFFF, 4'h8);
    attach(4'h2, 3'h4, 1, 0, 1, 16'h0001, 16'hFFFF, 4'h6);
    attach(4'h4, 3'h4, 1, 0, 0, 16'h0000, 16'h0000, 4'h0);
    attach(4'h0, 3'h6, 1, 0, 0, 16'h0000, 16'h0000, 4'h0);
    attach(4'h6, 3'h1, 0, 0, 0, 16'h0000, 16'h0000, 4'h0);
    setsw(1, 1, 4'hC);
    attach(4'hF, 3'h1, 1, 0, 1, 16'h0007, 16'hFF00, 4'h1);
    attach(4'h9, 3'h5, 1, 1, 1, 16'h0004, 16'hFFFF, 4'h8);
    attach(4'hA, 3'h5, 1, 0, 0, 16'h0000, 16'h0000, 4'h0);
    drop(4'h5, 0);
    `CHK({active_out_r[5], err_out_r[5]}, 2'b11)
    drop(4'hC, 0);
    `CHK(err_out_r[12], 1'b0)
    drop(4'h5, 1);
    `CHK({err_in_r[5], err_in_r[7]}, 2'b10)
    @(negedge ref_clk);
    restart = 1;
    @(negedge ref_clk);
    restart = 0;
    `CHK({active_out_r, active_in_r, err_out_r, err_in_r, link_ok_indicator}, 65'h0)
    attach(4'h4, 3'h1, 1, 0, 1, 16'h0002, 16'h00FF, 4'h1);
    `CHK(active_out_r, 16'h0010)
    give_verdict();
  end
endmodule
